// [pkg/chad_dec_if.sv]
// carrier between the top and the address decoder
`timescale 1ns/1ps
interface chad_dec_if
  import chad_pkg::*;
  ();
  chad_mode_e mode;
  logic [ADDR_W-1:0] addr;
  logic attr_n;
  logic io_cycle;
  logic ce_lo_n;
  logic ce_hi_n;
  chad_region_e region;
  logic [ADDR_W-1:0] index;
  logic word_odd;
  logic upper_set;

  modport top(
    output mode,
    output addr,
    output attr_n,
    output io_cycle,
    output ce_lo_n,
    output ce_hi_n,
    input region,
    input index,
    input word_odd,
    input upper_set
  );

  modport dec(
    input mode,
    input addr,
    input attr_n,
    input io_cycle,
    input ce_lo_n,
    input ce_hi_n,
    output region,
    output index,
    output word_odd,
    output upper_set
  );
endinterface

// [pkg/chad_pkg.sv]
// constants and types for the card host address decode block
package chad_pkg;
  localparam int ADDR_W = 11;
  localparam int TF_IDX_W = 3;
  // attribute-space address bit that splits card info bytes from config regs
  localparam int CFG_SEL_BIT = 9;
  localparam int ODD_BIT = 0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [TF_IDX_W-1:0] TF_IDX_RST = 3'h0;
  localparam logic [ADDR_W-1:TF_IDX_W] UPPER_ZERO = 8'h00;
  localparam logic PIN_NEGATED = 1'b1;
  localparam logic PIN_ASSERTED = 1'b0;

  typedef enum logic [1:0] {
    MODE_MEMORY,
    MODE_IO,
    MODE_DISK
  } chad_mode_e;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_IO_PORT,
    REG_MEM_PORT,
    REG_CIS,
    REG_CONFIG,
    REG_TASK_FILE
  } chad_region_e;

  typedef enum logic {
    ALERT_IDLE,
    ALERT_PENDING
  } chad_alert_e;
endpackage

// [rtl/chad_addr_decode.sv]
// combinational host address decoder for all three card modes
`timescale 1ns/1ps
module chad_addr_decode
  import chad_pkg::*;
(
  chad_dec_if.dec d
);
  always_comb
  begin
    d.region = REG_NONE;
    d.index = d.addr;
    d.word_odd = 1'b0;
    d.upper_set = 1'b0;
    if (d.mode == MODE_DISK)
    begin
      // upper lines ignored, only the low three pick a register
      d.region = REG_TASK_FILE; // RL4
      d.index = {UPPER_ZERO, d.addr[TF_IDX_W-1:0]}; // RL4
      // host is to ground them; flagged, never acted on
      d.upper_set = d.addr[ADDR_W-1:TF_IDX_W] != UPPER_ZERO; // RL5
    end
    else
    begin
      // io mode shares the memory-mode decode unchanged
      if (d.io_cycle) // RL3
      begin
        d.region = REG_IO_PORT; // RL1
      end
      else if (!d.attr_n)
      begin
        if (d.addr[CFG_SEL_BIT])
        begin
          d.region = REG_CONFIG; // RL1
        end
        else
        begin
          d.region = REG_CIS; // RL1
        end
      end
      else
      begin
        d.region = REG_MEM_PORT; // RL1
      end
      // odd-address word access to the register file is not honoured
      d.word_odd = !d.ce_lo_n && !d.ce_hi_n && d.addr[ODD_BIT]; // RL2
    end
  end
endmodule

// [rtl/chad_top.sv]
// card host port: address decode and status pin behaviour
// Summary of operation
// (RL1) memory mode: address lines plus attribute select pick port, info, config
// (RL2) word register access with both selects low and odd address unsupported
// (RL3) io mode decodes host address exactly as memory mode
// (RL4) disk mode: low three bits pick task file register, upper ignored
// (RL5) host grounds upper address lines in disk mode
// (RL6) memory mode drives first battery status permanently high
// (RL7) io mode drives status change low on ready or write-protect change
// (RL8) config status setting enables or suppresses status change output
// (RL9) disk mode: shared pin is bidirectional passed diagnostic signal
// (RL10) status change disabled keeps the pin negated high
`timescale 1ns/1ps
module chad_top
  import chad_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire chad_mode_e mode,
  input wire logic access,
  input wire logic io_cycle,
  input wire logic [ADDR_W-1:0] host_address_lines,
  input wire logic attr_select_n,
  input wire logic low_byte_card_select_n,
  input wire logic high_byte_card_select_n,
  input wire logic ready_state,
  input wire logic write_protect,
  input wire logic status_change_enable,
  input wire logic status_change_ack,
  input wire logic diag_passed,
  input wire logic status_pin_in,
  output logic status_pin_out,
  output logic status_pin_oe,
  output chad_region_e region_hit,
  output logic [ADDR_W-1:0] register_index,
  output logic [TF_IDX_W-1:0] task_file_index,
  output logic word_access_unsupported,
  output logic upper_address_misuse,
  output logic passed_diagnostic_seen
);
  chad_dec_if dif();
  chad_alert_e alert_state;
  chad_alert_e next_alert_state;
  logic ready_q;
  logic wp_q;
  logic change_event;

  assign dif.mode = mode;
  assign dif.addr = host_address_lines;
  assign dif.attr_n = attr_select_n;
  assign dif.io_cycle = io_cycle;
  assign dif.ce_lo_n = low_byte_card_select_n;
  assign dif.ce_hi_n = high_byte_card_select_n;

  chad_addr_decode u_dec (
    .d(dif.dec)
  );

  // decode results are held until the next access
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      region_hit <= REG_NONE;
      register_index <= ADDR_RST;
      task_file_index <= TF_IDX_RST;
      word_access_unsupported <= 1'b0;
      upper_address_misuse <= 1'b0;
    end
    else if (access)
    begin
      region_hit <= dif.region; // RL1
      register_index <= dif.index; // RL1
      task_file_index <= dif.index[TF_IDX_W-1:0]; // RL4
      word_access_unsupported <= dif.word_odd; // RL2
      upper_address_misuse <= dif.upper_set; // RL5
    end
  end

  // copies track through reset too, so a steady level is no false edge
  always_ff @(posedge mclk)
  begin
    ready_q <= ready_state;
    wp_q <= write_protect;
  end

  // only a level that moves after release counts as a change
  assign change_event = (ready_state != ready_q) || (write_protect != wp_q);

  always_comb
  begin
    next_alert_state = alert_state;
    case (alert_state)
      ALERT_IDLE:
      begin
        if (change_event && mode == MODE_IO)
        begin
          next_alert_state = ALERT_PENDING; // RL7
        end
      end
      ALERT_PENDING:
      begin
        // a new change in the ack cycle wins over the ack
        if (status_change_ack && !change_event)
        begin
          next_alert_state = ALERT_IDLE;
        end
        else if (mode != MODE_IO)
        begin
          next_alert_state = ALERT_IDLE;
        end
      end
      default:
      begin
        next_alert_state = ALERT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      alert_state <= ALERT_IDLE;
    end
    else
    begin
      alert_state <= next_alert_state;
    end
  end

  // the single shared pin changes meaning with the mode
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      status_pin_out <= PIN_NEGATED;
      status_pin_oe <= 1'b0;
    end
    else
    begin
      case (mode)
        MODE_MEMORY:
        begin
          status_pin_out <= PIN_NEGATED; // RL6
          status_pin_oe <= 1'b1; // RL6
        end
        MODE_IO:
        begin
          status_pin_oe <= 1'b1;
          if (status_change_enable && alert_state == ALERT_PENDING) // RL8
          begin
            status_pin_out <= PIN_ASSERTED; // RL7
          end
          else
          begin
            status_pin_out <= PIN_NEGATED; // RL10
          end
        end
        MODE_DISK:
        begin
          // open-drain style: only ever pull low, the other drive may too
          status_pin_out <= PIN_ASSERTED; // RL9
          status_pin_oe <= diag_passed; // RL9
        end
        default:
        begin
          status_pin_out <= PIN_NEGATED;
          status_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // other drive's passed signal, read when this end is not pulling
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      passed_diagnostic_seen <= 1'b0;
    end
    else
    begin
      passed_diagnostic_seen <= mode == MODE_DISK && !status_pin_oe
        && status_pin_in == PIN_ASSERTED; // RL9
    end
  end

  chk_cis_decode: assert property ( // RL1
    @(posedge mclk) disable iff (!rst_n)
    (access && mode == MODE_MEMORY && !io_cycle && !attr_select_n
      && !host_address_lines[CFG_SEL_BIT]) |=> region_hit == REG_CIS
  ) else $error("card info byte not decoded");

  chk_odd_word: assert property ( // RL2
    @(posedge mclk) disable iff (!rst_n)
    (access && mode != MODE_DISK && !low_byte_card_select_n
      && !high_byte_card_select_n && host_address_lines[ODD_BIT])
      |=> word_access_unsupported
  ) else $error("odd word access not flagged");

  chk_io_same: assert property ( // RL3
    @(posedge mclk) disable iff (!rst_n)
    (access && mode == MODE_IO && !io_cycle && !attr_select_n
      && host_address_lines[CFG_SEL_BIT]) |=> region_hit == REG_CONFIG
  ) else $error("io mode decode differs from memory mode");

  chk_task_index: assert property ( // RL4
    @(posedge mclk) disable iff (!rst_n)
    (access && mode == MODE_DISK) |=> (region_hit == REG_TASK_FILE
      && task_file_index == $past(host_address_lines[TF_IDX_W-1:0]))
  ) else $error("task file index wrong");

  chk_upper_flag: assert property ( // RL5
    @(posedge mclk) disable iff (!rst_n)
    (access && mode == MODE_DISK
      && host_address_lines[ADDR_W-1:TF_IDX_W] != UPPER_ZERO)
      |=> upper_address_misuse
  ) else $error("upper address use not flagged");

  chk_battery_high: assert property ( // RL6
    @(posedge mclk) disable iff (!rst_n)
    mode == MODE_MEMORY |=> (status_pin_oe && status_pin_out == PIN_NEGATED)
  ) else $error("battery status not high");

  chk_alert_low: assert property ( // RL7
    @(posedge mclk) disable iff (!rst_n)
    (($changed(ready_state) || $changed(write_protect)) && mode == MODE_IO)
      ##1 (mode == MODE_IO && status_change_enable && !status_change_ack)
      |=> status_pin_out == PIN_ASSERTED
  ) else $error("status change not signalled");

  chk_alert_off: assert property ( // RL10
    @(posedge mclk) disable iff (!rst_n)
    (mode == MODE_IO && !status_change_enable)
      |=> (status_pin_oe && status_pin_out == PIN_NEGATED)
  ) else $error("disabled status change not negated");

  chk_diag_pull: assert property ( // RL9
    @(posedge mclk) disable iff (!rst_n)
    mode == MODE_DISK |=> (status_pin_oe == $past(diag_passed)
      && status_pin_out == PIN_ASSERTED)
  ) else $error("passed diagnostic drive wrong");
endmodule

// [tb/chad_host_model.sv]
// host side model of the shared status pin with its bus pull-up
`timescale 1ns/1ps
module chad_host_model
(
  input wire logic status_pin_out,
  input wire logic status_pin_oe,
  input wire logic other_drive_low,
  output logic status_pin_in
);
  logic self_low;
  // pull-up wins unless a drive pulls low
  assign self_low = status_pin_oe && !status_pin_out;
  assign status_pin_in = (self_low || other_drive_low) ? 1'b0 : 1'b1;
endmodule

// [tb/testbench.sv]
// self-checking bench for the card host address decode block
`timescale 1ns/1ps
module testbench
  import chad_pkg::*;
();
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  chad_mode_e mode = MODE_MEMORY;
  logic access = 1'b0, io_cycle = 1'b0, attr_n = 1'b1;
  logic ce_lo_n = 1'b1, ce_hi_n = 1'b1, ready = 1'b0, wp = 1'b0;
  logic en = 1'b0, ack = 1'b0, diag = 1'b0, other_low = 1'b0;
  logic [10:0] addr = 11'h000;
  logic pin_in, pin_out, pin_oe, word_bad, misuse, seen;
  chad_region_e region;
  logic [10:0] idx;
  logic [2:0] tfi;
  int bad_count = 0;
  int check_count = 0;

  always #12.5 mclk = ~mclk;

  chad_top u_chad_top (.mclk(mclk), .rst_n(rst_n), .mode(mode),
    .access(access), .io_cycle(io_cycle), .host_address_lines(addr),
    .attr_select_n(attr_n), .low_byte_card_select_n(ce_lo_n),
    .high_byte_card_select_n(ce_hi_n), .ready_state(ready),
    .write_protect(wp), .status_change_enable(en),
    .status_change_ack(ack), .diag_passed(diag),
    .status_pin_in(pin_in), .status_pin_out(pin_out),
    .status_pin_oe(pin_oe), .region_hit(region), .register_index(idx),
    .task_file_index(tfi), .word_access_unsupported(word_bad),
    .upper_address_misuse(misuse), .passed_diagnostic_seen(seen));

  chad_host_model u_chad_host_model (.status_pin_out(pin_out),
    .status_pin_oe(pin_oe), .other_drive_low(other_low),
    .status_pin_in(pin_in));

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic chk_f(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      $display("Error %s expected %b seen %b", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic chk_n(input string nm, input logic [10:0] e,
    input logic [10:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic chk_r(input string nm, input chad_region_e e,
    input chad_region_e g);
    check_count++;
    if (g !== e)
    begin
      $display("Error %s expected %0d seen %0d", nm, e, g);
      bad_count++;
    end
  endtask

  // one sampled access, then the registered answer has settled
  task automatic decode(input chad_mode_e m, input logic io,
    input logic a_n, input logic [10:0] a, input logic lo_n);
    mode = m;
    io_cycle = io;
    attr_n = a_n;
    addr = a;
    ce_lo_n = lo_n;
    ce_hi_n = 1'b0;
    access = 1'b1;
    step(1);
    access = 1'b0;
    step(1);
  endtask

  task automatic test_decode;
    chad_mode_e ms [2];
    ms = '{MODE_MEMORY, MODE_IO};
    for (int i = 0; i < 2; i++)
    begin
      decode(ms[i], 1'b0, 1'b0, 11'h205, 1'b1);
      chk_r("config", REG_CONFIG, region);
      chk_n("config index", 11'h205, idx);
      decode(ms[i], 1'b0, 1'b0, 11'h005, 1'b1);
      chk_r("info byte", REG_CIS, region);
      decode(ms[i], 1'b0, 1'b1, 11'h010, 1'b1);
      chk_r("mem port", REG_MEM_PORT, region);
      decode(ms[i], 1'b1, 1'b1, 11'h3f1, 1'b1);
      chk_r("io port", REG_IO_PORT, region);
      chk_n("io index", 11'h3f1, idx);
    end
    $display("test decode done");
  endtask

  task automatic test_odd_word;
    decode(MODE_MEMORY, 1'b0, 1'b1, 11'h001, 1'b0);
    chk_f("odd word", 1'b1, word_bad);
    decode(MODE_IO, 1'b0, 1'b1, 11'h002, 1'b0);
    chk_f("even word", 1'b0, word_bad);
    decode(MODE_MEMORY, 1'b0, 1'b1, 11'h001, 1'b1);
    chk_f("odd byte", 1'b0, word_bad);
    $display("test odd word done");
  endtask

  task automatic test_disk;
    decode(MODE_DISK, 1'b0, 1'b1, 11'h7fd, 1'b1);
    chk_r("task file", REG_TASK_FILE, region);
    chk_n("tf index", 11'h005, {8'h00, tfi});
    chk_f("misuse set", 1'b1, misuse);
    decode(MODE_DISK, 1'b0, 1'b1, 11'h003, 1'b1);
    chk_n("tf index low", 11'h003, {8'h00, tfi});
    chk_f("misuse clear", 1'b0, misuse);
    $display("test disk done");
  endtask

  task automatic test_pins;
    mode = MODE_MEMORY;
    step(3);
    chk_f("battery out", 1'b1, pin_out);
    chk_f("battery oe", 1'b1, pin_oe);
    mode = MODE_IO;
    en = 1'b1;
    step(3);
    chk_f("alert quiet", 1'b1, pin_out);
    ready = 1'b1;
    step(3);
    chk_f("alert low", 1'b0, pin_out);
    chk_f("alert oe", 1'b1, pin_oe);
    ack = 1'b1;
    step(1);
    ack = 1'b0;
    step(3);
    chk_f("alert cleared", 1'b1, pin_out);
    en = 1'b0;
    wp = 1'b1;
    step(3);
    chk_f("alert off", 1'b1, pin_out);
    mode = MODE_DISK;
    diag = 1'b1;
    step(3);
    chk_f("diag oe", 1'b1, pin_oe);
    chk_f("diag out", 1'b0, pin_out);
    diag = 1'b0;
    other_low = 1'b1;
    step(3);
    chk_f("diag seen", 1'b1, seen);
    other_low = 1'b0;
    step(3);
    chk_f("diag gone", 1'b0, seen);
    chk_f("diag released", 1'b0, pin_oe);
    $display("test pins done");
  endtask

  // mid-run reset with ready and write-protect held high throughout
  task automatic test_reset;
    mode = MODE_IO;
    en = 1'b1;
    rst_n = 1'b0;
    step(2);
    chk_r("reset region", REG_NONE, region);
    chk_n("reset index", 11'h000, idx);
    chk_n("reset tf index", 11'h000, {8'h00, tfi});
    chk_f("reset word", 1'b0, word_bad);
    chk_f("reset misuse", 1'b0, misuse);
    chk_f("reset seen", 1'b0, seen);
    chk_f("reset oe", 1'b0, pin_oe);
    chk_f("reset out", 1'b1, pin_out);
    rst_n = 1'b1;
    step(3);
    chk_f("no false alert", 1'b1, pin_out);
    chk_f("io oe", 1'b1, pin_oe);
    $display("test reset done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    step(5);
    rst_n = 1'b1;
    test_decode();
    test_odd_word();
    test_disk();
    test_pins();
    test_reset();
    tally_and_finish();
  end
endmodule
